//--- rtl/wdc_pkg.sv
// ****************************************************************
// Watchdog control constants
// ****************************************************************
package wdc_pkg;
    // Register byte offsets
    localparam logic [7:0] WDC_OFF_CTL = 8'h00;
    localparam logic [7:0] WDC_OFF_CAUSE = 8'h04;
    localparam logic [7:0] WDC_OFF_CMD = 8'h08;
    localparam logic [7:0] WDC_OFF_STS = 8'h0C;
    localparam logic [7:0] WDC_OFF_MASK = 8'h10;

    // Control/status field positions
    localparam int WDC_B_IF = 7;
    localparam int WDC_B_IE = 6;
    localparam int WDC_B_SEL3 = 5;
    localparam int WDC_B_CE = 4;
    localparam int WDC_B_RE = 3;
    localparam int WDC_B_SEL_HI = 2;
    localparam int WDC_B_CAUSE = 3;
    localparam int WDC_B_RESTART = 0;
    localparam int WDC_B_EV_TO = 0;
    localparam int WDC_B_EV_RST = 1;

    // Reset values
    localparam logic [3:0] WDC_SEL_RST = 4'h0;
    localparam logic [1:0] WDC_EV_RST_VAL = 2'h0;

    // Cycle counts
    localparam logic [2:0] WDC_UNLOCK_CYCLES = 3'h4;
    localparam logic [20:0] WDC_BASE_CYCLES = 21'h00_0800;
    localparam logic [3:0] WDC_SEL_MAX = 4'h9;

    // Watchdog modes, one-hot
    typedef enum logic [3:0] {
        WDC_MODE_STOP = 4'b0001,
        WDC_MODE_IRQ = 4'b0010,
        WDC_MODE_RST = 4'b0100,
        WDC_MODE_BOTH = 4'b1000
    } wdc_mode_t;

    // Last count of a period; reserved codes fall back to the longest
    function automatic logic [19:0] wdc_last(input logic [3:0] sel);
        logic [3:0] s;
        logic [20:0] p;
        s = (sel > WDC_SEL_MAX) ? WDC_SEL_MAX : sel;
        p = WDC_BASE_CYCLES << s;
        p = p - 21'h00_0001;
        return p[19:0];
    endfunction
endpackage

//--- rtl/wdc_cnt_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Control to counter link
// ****************************************************************
interface wdc_cnt_if;
    logic tick;
    logic run;
    logic restart;
    logic [3:0] sel;
    logic timeout;
    logic [19:0] count;

    modport ctl (output tick, output run, output restart, output sel,
                 input timeout, input count);
    modport cnt (input tick, input run, input restart, input sel,
                 output timeout, output count);
endinterface

//--- rtl/wdc_counter.sv
`timescale 1ns/1ps
// ****************************************************************
// Watchdog oscillator cycle counter
// ****************************************************************
module wdc_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to control
    wdc_cnt_if.cnt cif
);
    import wdc_pkg::*;

    logic [19:0] count_q;
    logic timeout_q;
    logic [19:0] last;

    // Selected period, only looked at while running
    assign last = wdc_last(cif.sel);

    // Count ticks, wrap and flag at the selected period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 20'h0_0000;
            timeout_q <= 1'b0;
        end else if (cif.restart || !cif.run) begin
            count_q <= 20'h0_0000;
            timeout_q <= 1'b0;
        end else if (cif.tick && count_q == last) begin
            count_q <= 20'h0_0000;
            timeout_q <= 1'b1;
        end else begin
            count_q <= cif.tick ? count_q + 20'h0_0001 : count_q;
            timeout_q <= 1'b0;
        end
    end

    assign cif.count = count_q;
    assign cif.timeout = timeout_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_RESTART_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        cif.restart |=> (count_q == 20'h0_0000) && !timeout_q)
        else $error("count not cleared by restart");
    AST_STOPPED_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        !cif.run |=> !timeout_q)
        else $error("timeout while stopped");
    AST_PERIOD_END: assert property (@(posedge clk) disable iff (!rst_n)
        timeout_q |-> $past(count_q) == $past(last) && count_q == 20'h0_0000)
        else $error("timeout not at selected period");
endmodule

//--- rtl/wdc_top.sv
`timescale 1ns/1ps
// Operation
// - Unlock bit self-clears after four cycles
// - Reset enable reads set while cause flag set
// - Reset enable clears only after flag cleared
// - Four-bit select at bits 5 and 2:0
// - Period is 2048 times two to select, select capped at 9
// - Select governs counting only while running
// - Enables choose interrupt, reset or stopped mode
// - Both enabled: interrupt first, then reset
// - Interrupt flag set on timeout in interrupt or dual mode, cleared two ways
module wdc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Watchdog oscillator and CPU side
    input wire logic wd_osc,
    input wire logic vec_ack,
    output logic wd_irq_req,
    output logic sys_reset_req,
    // Summary interrupt
    output logic irq
);
    import wdc_pkg::*;

    wdc_cnt_if cif ();

    logic ack_q;
    logic req;
    logic wr_acc;
    logic rd_take;
    logic [7:0] wd;
    logic hit_ctl;
    logic hit_cause;
    logic hit_cmd;
    logic hit_sts;
    logic hit_mask;
    logic wd_irq_flag_q;
    logic wd_irq_enable_q;
    logic wde_q;
    logic wde_eff;
    logic [3:0] sel_q;
    logic [2:0] unl_cnt_q;
    logic unlock;
    logic open_req;
    logic cause_q;
    logic osc_q;
    logic set_if;
    logic rst_ev;
    logic rst_q;
    logic [1:0] sts_q;
    logic [1:0] mask_q;
    logic [7:0] ctl_view;
    logic [31:0] rd_d;
    wdc_mode_t mode;

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // One wait state: answer lands on the second edge after the request rises
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_acc = avs_write & ack_q & avs_byteenable[0];
    assign rd_take = avs_read & ~ack_q;
    assign wd = avs_writedata[7:0];
    assign hit_ctl = wr_acc && avs_address == WDC_OFF_CTL;
    assign hit_cause = wr_acc && avs_address == WDC_OFF_CAUSE;
    assign hit_cmd = wr_acc && avs_address == WDC_OFF_CMD;
    assign hit_sts = wr_acc && avs_address == WDC_OFF_STS;
    assign hit_mask = wr_acc && avs_address == WDC_OFF_MASK;

    // Acknowledge toggles so back-to-back requests each wait once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address)
            WDC_OFF_CTL: rd_d[7:0] = ctl_view;
            WDC_OFF_CAUSE: rd_d[WDC_B_CAUSE] = cause_q;
            WDC_OFF_STS: rd_d[1:0] = sts_q;
            WDC_OFF_MASK: rd_d[1:0] = mask_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= rd_d;
        end
    end

    // ****************************************************************
    // Control and status register
    // ****************************************************************
    assign unlock = unl_cnt_q != 3'h0;
    assign wde_eff = wde_q | cause_q;
    assign open_req = hit_ctl && wd[WDC_B_CE] && wd[WDC_B_RE];
    assign ctl_view = {wd_irq_flag_q, wd_irq_enable_q, sel_q[3], unlock, wde_eff, sel_q[2:0]};

    // Unlock window; a fresh open restarts the four cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unl_cnt_q <= 3'h0;
        end else if (open_req) begin
            unl_cnt_q <= WDC_UNLOCK_CYCLES;
        end else if (unlock) begin
            unl_cnt_q <= unl_cnt_q - 3'h1;
        end
    end

    // Reset enable: set freely, cleared only inside the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wde_q <= 1'b0;
        end else if (hit_ctl && unlock) begin
            wde_q <= wd[WDC_B_RE] | cause_q;
        end else if (hit_ctl) begin
            wde_q <= wde_q | wd[WDC_B_RE];
        end
    end

    // Period select only moves inside the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= WDC_SEL_RST;
        end else if (hit_ctl && unlock) begin
            sel_q <= {wd[WDC_B_SEL3], wd[WDC_B_SEL_HI:0]};
        end
    end

    // Interrupt enable; servicing in dual mode drops back to reset mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_irq_enable_q <= 1'b0;
        end else if (hit_ctl) begin
            wd_irq_enable_q <= wd[WDC_B_IE];
        end else if (vec_ack && mode == WDC_MODE_BOTH) begin
            wd_irq_enable_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Timeout actions
    // ****************************************************************
    assign mode = (wde_eff && wd_irq_enable_q) ? WDC_MODE_BOTH :
                  wde_eff ? WDC_MODE_RST :
                  wd_irq_enable_q ? WDC_MODE_IRQ : WDC_MODE_STOP;

    // Dual mode resets only if the first interrupt went unserviced
    always_comb begin
        set_if = 1'b0;
        rst_ev = 1'b0;
        unique case (mode)
            WDC_MODE_STOP: set_if = 1'b0;
            WDC_MODE_IRQ: set_if = cif.timeout;
            WDC_MODE_RST: rst_ev = cif.timeout;
            WDC_MODE_BOTH: begin
                set_if = cif.timeout & ~wd_irq_flag_q;
                rst_ev = cif.timeout & wd_irq_flag_q;
            end
        endcase
    end

    // Interrupt flag: set wins over vector or write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_irq_flag_q <= 1'b0;
        end else if (set_if) begin
            wd_irq_flag_q <= 1'b1;
        end else if (vec_ack || (hit_ctl && wd[WDC_B_IF])) begin
            wd_irq_flag_q <= 1'b0;
        end
    end

    // Reset cause flag: watchdog reset sets it, writing zero clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_q <= 1'b0;
        end else if (rst_ev) begin
            cause_q <= 1'b1;
        end else if (hit_cause && !wd[WDC_B_CAUSE]) begin
            cause_q <= 1'b0;
        end
    end

    // System reset request, one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 1'b0;
        end else begin
            rst_q <= rst_ev;
        end
    end
    assign sys_reset_req = rst_q;
    assign wd_irq_req = wd_irq_flag_q & wd_irq_enable_q;

    // ****************************************************************
    // Counter hookup
    // ****************************************************************
    // Oscillator taken as synchronous; rising edge is one tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= wd_osc;
        end
    end
    assign cif.tick = wd_osc & ~osc_q;
    assign cif.run = mode != WDC_MODE_STOP;
    assign cif.restart = hit_cmd && wd[WDC_B_RESTART];
    assign cif.sel = sel_q;

    wdc_counter u_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    // ****************************************************************
    // Event status and mask
    // ****************************************************************
    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_q <= WDC_EV_RST_VAL;
        end else begin
            sts_q[WDC_B_EV_TO] <= cif.timeout |
                (sts_q[WDC_B_EV_TO] & ~(hit_sts & wd[WDC_B_EV_TO]));
            sts_q[WDC_B_EV_RST] <= rst_ev |
                (sts_q[WDC_B_EV_RST] & ~(hit_sts & wd[WDC_B_EV_RST]));
        end
    end

    // Mask, same layout as status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= WDC_EV_RST_VAL;
        end else if (hit_mask) begin
            mask_q <= wd[1:0];
        end
    end
    assign irq = |(sts_q & mask_q);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_open;
        open_req;
    endsequence
    sequence s_quiet4;
        (!open_req) [*4];
    endsequence

    AST_UNLOCK_HOLD: assert property (s_open |=> unlock [*4])
        else $error("unlock window shorter than four cycles");
    AST_UNLOCK_CLOSE: assert property (s_open ##1 s_quiet4 |=> !unlock)
        else $error("unlock not cleared after four cycles");
    AST_WDE_FORCED: assert property (cause_q |-> ctl_view[WDC_B_RE])
        else $error("reset enable not forced by cause flag");
    AST_WDE_KEEP: assert property (cause_q && hit_ctl |=> wde_q)
        else $error("reset enable cleared while cause flag set");
    AST_SEL_LOCK: assert property (hit_ctl && !unlock |=> $stable(sel_q))
        else $error("select changed without unlock");
    AST_IRQ_MODE: assert property (cif.timeout && mode == WDC_MODE_IRQ
        |=> wd_irq_flag_q && !sys_reset_req)
        else $error("interrupt mode timeout wrong");
    AST_RST_MODE: assert property (cif.timeout && mode == WDC_MODE_RST
        |=> sys_reset_req && cause_q)
        else $error("reset mode timeout did not reset");
    AST_BOTH_FIRST: assert property (cif.timeout && mode == WDC_MODE_BOTH && !wd_irq_flag_q
        |=> wd_irq_flag_q && !sys_reset_req ##1 !sys_reset_req)
        else $error("dual mode first timeout wrong");
    AST_BOTH_SERVICE: assert property (vec_ack && mode == WDC_MODE_BOTH && !hit_ctl
        && !cif.timeout |=> !wd_irq_enable_q && !wd_irq_flag_q)
        else $error("servicing did not clear enable and flag");
    AST_IF_W1C: assert property (hit_ctl && wd[WDC_B_IF] && !set_if |=> !wd_irq_flag_q)
        else $error("interrupt flag not cleared by write one");
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// Watchdog control testbench
// ****************************************************************
module testbench;
    import wdc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic wd_osc = 1'b0;
    logic osc_en = 1'b0;
    logic vec_ack = 1'b0;
    logic wd_irq_req;
    logic sys_reset_req;
    logic irq;
    logic [31:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_rst = 0;
    int wt = 0;
    int t0 = 0;

    wdc_top uut (
        .clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wd_osc(wd_osc), .vec_ack(vec_ack), .wd_irq_req(wd_irq_req),
        .sys_reset_req(sys_reset_req), .irq(irq)
    );

    // ****************************************************************
    // Clock, oscillator and monitors
    // ****************************************************************
    // Clock at 100 MHz
    always #5 clk = ~clk;

    // Fastest legal oscillator: one tick every two clocks
    always @(posedge clk) begin
        if (osc_en) begin
            wd_osc <= ~wd_osc;
        end
    end

    // Count reset-request cycles; a wider pulse shows up as extra counts
    always @(posedge clk) begin
        cycles++;
        if (sys_reset_req === 1'b1) begin
            n_rst++;
        end
        if (cycles == 60000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon transfer; an idle edge first keeps drives apart
    task automatic bus(input logic is_wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= {24'h00_0000, data};
        avs_write <= is_wr;
        avs_read <= ~is_wr;
        // Hold everything until waitrequest is seen low at a rising edge
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Summary interrupt moves on the write edge; look once it has settled
    task automatic irq_chk(input string what, input logic exp);
        @(negedge clk);
        check(what, {31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        bus(1'b1, addr, data);
    endtask

    task automatic rchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        bus(1'b0, addr, 8'h00);
        check(what, rd, {24'h00_0000, exp});
    endtask

    // Open the change window, then store the protected value at once
    task automatic unlock_wr(input logic [7:0] data);
        wr(WDC_OFF_CTL, 8'h18);
        wr(WDC_OFF_CTL, data);
    endtask

    // Cycles until an interrupt request or a reset pulse, bounded
    task automatic wait_to(input int lim);
        int r0;
        r0 = n_rst;
        wt = 0;
        while (wd_irq_req !== 1'b1 && n_rst == r0 && wt < lim) begin
            @(negedge clk);
            wt++;
        end
    endtask

    // Period check: two clocks per tick, small slack for latency
    task automatic period_chk(input string what, input int sel);
        int p;
        p = 2 * (int'(WDC_BASE_CYCLES) << sel);
        check(what, 32'((wt >= p - 6) && (wt <= p + 10)), 32'h0000_0001);
    endtask

    task automatic ack_vector;
        @(posedge clk);
        vec_ack <= 1'b1;
        @(posedge clk);
        vec_ack <= 1'b0;
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] offs [6];
        offs = '{WDC_OFF_CTL, WDC_OFF_CAUSE, WDC_OFF_CMD, WDC_OFF_STS, WDC_OFF_MASK, 8'h14};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        osc_en <= 1'b1;
        // Reset values, write-only command and unmapped offset all read 0
        foreach (offs[i]) rchk("reset value", offs[i], 8'h00);
        // Locked select ignores writes; reset enable may only be set
        wr(WDC_OFF_CTL, 8'h27);
        rchk("locked select", WDC_OFF_CTL, 8'h00);
        avs_byteenable <= 4'h0;
        wr(WDC_OFF_CTL, 8'h40);
        avs_byteenable <= 4'h1;
        rchk("byte lane off", WDC_OFF_CTL, 8'h00);
        wr(WDC_OFF_CTL, 8'h08);
        wr(WDC_OFF_CTL, 8'h00);
        rchk("locked enable", WDC_OFF_CTL, 8'h08);
        // Window opens, then closes by itself
        wr(WDC_OFF_CTL, 8'h18);
        rchk("window open", WDC_OFF_CTL, 8'h18);
        repeat (6) @(posedge clk);
        rchk("window shut", WDC_OFF_CTL, 8'h08);
        wr(WDC_OFF_CTL, 8'h01);
        rchk("late change", WDC_OFF_CTL, 8'h08);
        // Highest select code lands at bit 5 and bit 0
        unlock_wr(8'h21);
        rchk("select layout", WDC_OFF_CTL, 8'h21);
        // Interrupt mode, shortest period
        unlock_wr(8'h40);
        rchk("irq mode", WDC_OFF_CTL, 8'h40);
        wr(WDC_OFF_CMD, 8'h01);
        wait_to(9000);
        period_chk("period sel 0", 0);
        rchk("flag set", WDC_OFF_CTL, 8'hC0);
        check("no reset in irq mode", n_rst, 0);
        rchk("timeout event", WDC_OFF_STS, 8'h01);
        irq_chk("irq masked", 1'b0);
        wr(WDC_OFF_MASK, 8'h01);
        irq_chk("irq unmasked", 1'b1);
        wr(WDC_OFF_STS, 8'h01);
        irq_chk("irq cleared", 1'b0);
        wr(WDC_OFF_CTL, 8'hC0);
        rchk("flag write one", WDC_OFF_CTL, 8'h40);
        // A restart mid-period pushes the timeout back
        wr(WDC_OFF_CMD, 8'h01);
        repeat (3000) @(posedge clk);
        wr(WDC_OFF_CMD, 8'h01);
        wait_to(9000);
        period_chk("restart period", 0);
        ack_vector();
        rchk("flag by vector", WDC_OFF_CTL, 8'h40);
        // Next select code doubles the period
        unlock_wr(8'h41);
        wr(WDC_OFF_CMD, 8'h01);
        wait_to(12000);
        period_chk("period sel 1", 1);
        // Clearing the enable stops the watchdog
        wr(WDC_OFF_CTL, 8'h80);
        wr(WDC_OFF_STS, 8'h01);
        rchk("stopped", WDC_OFF_CTL, 8'h01);
        wait_to(9000);
        check("no timeout stopped", wt, 9000);
        rchk("no event stopped", WDC_OFF_STS, 8'h00);
        // Both enables: interrupt first, then reset
        unlock_wr(8'h48);
        wr(WDC_OFF_CMD, 8'h01);
        wait_to(9000);
        t0 = cycles;
        period_chk("both first", 0);
        rchk("both flag", WDC_OFF_CTL, 8'hC8);
        ack_vector();
        rchk("vector drops enable", WDC_OFF_CTL, 8'h08);
        wait_to(9000);
        // Reset comes one period after the first timeout, not after the service
        wt = cycles - t0;
        period_chk("both second", 0);
        check("one reset pulse", n_rst, 1);
        rchk("cause flag", WDC_OFF_CAUSE, 8'h08);
        rchk("both events", WDC_OFF_STS, 8'h03);
        // Cause flag holds the enable until cleared
        unlock_wr(8'h00);
        rchk("enable held", WDC_OFF_CTL, 8'h08);
        wr(WDC_OFF_CAUSE, 8'h00);
        rchk("cause cleared", WDC_OFF_CAUSE, 8'h00);
        unlock_wr(8'h00);
        rchk("enable released", WDC_OFF_CTL, 8'h00);
        check("no second reset", n_rst, 1);
        end_of_test();
    end
endmodule
